// [hdl/sfeg_pkg.sv]
/*
 * sfeg_pkg: register addresses, field positions, reset values and serial
 * frame layout for the frame, exposure and gain register slice.
 * Assumes: 9-bit register addresses and 16-bit register data.
 */
package sfeg_pkg;
   // ------------------------------------------------------------
   // register addresses
   // ------------------------------------------------------------
   localparam logic [8:0] ADDR_DARK_ROW_SETUP = 9'h0C5;
   localparam logic [8:0] ADDR_FILLER_ROW_COUNT = 9'h0C6;
   localparam logic [8:0] ADDR_TIME_UNIT_DIVIDER = 9'h0C7;
   localparam logic [8:0] ADDR_FRAME_PERIOD_LENGTH = 9'h0C8;
   localparam logic [8:0] ADDR_INTEGRATION_TIME = 9'h0C9;
   localparam logic [8:0] ADDR_INTEGRATION_TIME_SECOND_SLOPE = 9'h0CA;
   localparam logic [8:0] ADDR_INTEGRATION_TIME_THIRD_SLOPE = 9'h0CB;
   localparam logic [8:0] ADDR_ANALOG_GAIN_SETUP = 9'h0CC;
   localparam logic [8:0] ADDR_DIGITAL_GAIN_SETUP = 9'h0CD;

   // ------------------------------------------------------------
   // writable bit masks (other bits read as zero)
   // ------------------------------------------------------------
   localparam logic [15:0] MASK_DARK_ROW_SETUP = 16'h01FF;
   localparam logic [15:0] MASK_FILLER_ROW_COUNT = 16'h0FFF;
   localparam logic [15:0] MASK_FULL = 16'hFFFF;
   localparam logic [15:0] MASK_ANALOG_GAIN_SETUP = 16'h3FFF;
   localparam logic [15:0] MASK_DIGITAL_GAIN_SETUP = 16'h0FFF;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [15:0] RST_DARK_ROW_SETUP = 16'h0102;
   localparam logic [15:0] RST_FILLER_ROW_COUNT = 16'h0000;
   localparam logic [15:0] RST_TIME_UNIT_DIVIDER = 16'h0001;
   localparam logic [15:0] RST_ZERO = 16'h0000;
   localparam logic [15:0] RST_ANALOG_GAIN_SETUP = 16'h01E2;
   localparam logic [15:0] RST_DIGITAL_GAIN_SETUP = 16'h0080;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int DARK_COUNT_MSB = 7;
   localparam int BLANK_FIRST_BIT = 8;
   localparam int FILLER_MSB = 11;
   localparam int GAIN_FIRST_MSB = 4;
   localparam int GAIN_SECOND_LSB = 5;
   localparam int GAIN_SECOND_MSB = 12;
   localparam int GAIN_LAT_COMP_BIT = 13;
   localparam int DIGITAL_GAIN_MSB = 11;
   localparam logic [7:0] DARK_COUNT_MIN = 8'h01;

   // ------------------------------------------------------------
   // serial frame: 9 address bits, 1 write bit, 16 data bits
   // ------------------------------------------------------------
   localparam logic [4:0] SER_ADDR_LAST = 5'h08;
   localparam logic [4:0] SER_RW_BIT = 5'h09;
   localparam logic [4:0] SER_FIRST_DATA = 5'h0A;
   localparam logic [4:0] SER_LAST_BIT = 5'h19;
endpackage

// [hdl/sfeg_regs.sv]
/*
 * sfeg_regs: frame timing, exposure and gain configuration registers with
 * frame-start synchronised active copies and a time unit tick.
 * Assumes: frame_start and line_tick are one-cycle pulses on clock; the
 * shutter, representation and sync select levels come from the sequencer.
 */
// How it works
// - dark line count 1..255, reset two
// - blank first line bit, reset set
// - filler lines only in rolling shutter
// - time unit is multiplier clock periods
// - length is reset or frame length, global shutter only
// - exposure in lines or time units
// - second slope used only in global
// - third slope used only in global
// - latency compensation delays analog gain one frame
// - otherwise gain applies next frame start
// - representation select picks reset or frame
// - shutter select picks global or rolling
// - exposure updates synchronised to frame start
`timescale 1ns/1ps
`default_nettype none
module sfeg_regs
   import sfeg_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic ser_clock,
   input wire logic ser_select_n,
   input wire logic ser_data_in,
   output logic ser_data_out,
   output logic ser_data_out_oe,
   input wire logic rolling_shutter_enable,
   input wire logic period_representation_select,
   input wire logic exposure_sync_enable,
   input wire logic frame_start,
   input wire logic line_tick,
   output logic [7:0] dark_line_count,
   output logic blank_first_line,
   output logic [11:0] filler_line_count,
   output logic [15:0] time_unit_length,
   output logic time_unit_tick,
   output logic [15:0] reset_length,
   output logic [15:0] frame_length,
   output logic exposure_tick,
   output logic [15:0] integration_time_active,
   output logic [15:0] second_slope_integration_time,
   output logic [15:0] third_slope_integration_time,
   output logic [4:0] analog_gain_first,
   output logic [7:0] analog_gain_second,
   output logic [11:0] digital_gain_value
);
   // ------------------------------------------------------------
   // serial port
   // ------------------------------------------------------------
   logic [8:0] reg_addr;
   logic reg_write;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;

   sfeg_serial_port i_sfeg_serial_port (
      .clock(clock),
      .reset(reset),
      .ser_clock(ser_clock),
      .ser_select_n(ser_select_n),
      .ser_data_in(ser_data_in),
      .ser_data_out(ser_data_out),
      .ser_data_out_oe(ser_data_out_oe),
      .reg_addr(reg_addr),
      .reg_write(reg_write),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata)
   );

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   logic [15:0] dark_row_setup;
   logic [15:0] filler_row_count;
   logic [15:0] time_unit_divider;
   logic [15:0] frame_period_length;
   logic [15:0] integration_time;
   logic [15:0] integration_time_second_slope;
   logic [15:0] integration_time_third_slope;
   logic [15:0] analog_gain_setup;
   logic [15:0] digital_gain_setup;

   // write strobes per address
   wire wr_dark = reg_write && (reg_addr == ADDR_DARK_ROW_SETUP);
   wire wr_filler = reg_write && (reg_addr == ADDR_FILLER_ROW_COUNT);
   wire wr_unit = reg_write && (reg_addr == ADDR_TIME_UNIT_DIVIDER);
   wire wr_length = reg_write && (reg_addr == ADDR_FRAME_PERIOD_LENGTH);
   wire wr_exp = reg_write && (reg_addr == ADDR_INTEGRATION_TIME);
   wire wr_exp2 = reg_write && (reg_addr == ADDR_INTEGRATION_TIME_SECOND_SLOPE);
   wire wr_exp3 = reg_write && (reg_addr == ADDR_INTEGRATION_TIME_THIRD_SLOPE);
   wire wr_again = reg_write && (reg_addr == ADDR_ANALOG_GAIN_SETUP);
   wire wr_dgain = reg_write && (reg_addr == ADDR_DIGITAL_GAIN_SETUP);

   always_ff @(posedge clock) begin
      if (reset) begin
         dark_row_setup <= RST_DARK_ROW_SETUP;
         filler_row_count <= RST_FILLER_ROW_COUNT;
         time_unit_divider <= RST_TIME_UNIT_DIVIDER;
         frame_period_length <= RST_ZERO;
         integration_time <= RST_ZERO;
         integration_time_second_slope <= RST_ZERO;
         integration_time_third_slope <= RST_ZERO;
         analog_gain_setup <= RST_ANALOG_GAIN_SETUP;
         digital_gain_setup <= RST_DIGITAL_GAIN_SETUP;
      end else begin
         if (wr_dark) dark_row_setup <= reg_wdata & MASK_DARK_ROW_SETUP;
         if (wr_filler) filler_row_count <= reg_wdata & MASK_FILLER_ROW_COUNT;
         if (wr_unit) time_unit_divider <= reg_wdata;
         if (wr_length) frame_period_length <= reg_wdata;
         if (wr_exp) integration_time <= reg_wdata;
         if (wr_exp2) integration_time_second_slope <= reg_wdata;
         if (wr_exp3) integration_time_third_slope <= reg_wdata;
         if (wr_again) analog_gain_setup <= reg_wdata & MASK_ANALOG_GAIN_SETUP;
         if (wr_dgain) digital_gain_setup <= reg_wdata & MASK_DIGITAL_GAIN_SETUP;
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      unique case (reg_addr)
         ADDR_DARK_ROW_SETUP: reg_rdata = dark_row_setup;
         ADDR_FILLER_ROW_COUNT: reg_rdata = filler_row_count;
         ADDR_TIME_UNIT_DIVIDER: reg_rdata = time_unit_divider;
         ADDR_FRAME_PERIOD_LENGTH: reg_rdata = frame_period_length;
         ADDR_INTEGRATION_TIME: reg_rdata = integration_time;
         ADDR_INTEGRATION_TIME_SECOND_SLOPE: reg_rdata = integration_time_second_slope;
         ADDR_INTEGRATION_TIME_THIRD_SLOPE: reg_rdata = integration_time_third_slope;
         ADDR_ANALOG_GAIN_SETUP: reg_rdata = analog_gain_setup;
         ADDR_DIGITAL_GAIN_SETUP: reg_rdata = digital_gain_setup;
         default: reg_rdata = 16'h0000;
      endcase
   end

   // ------------------------------------------------------------
   // active copies, taken at frame start
   // ------------------------------------------------------------
   logic [15:0] exp_active;
   logic [15:0] exp2_active;
   logic [15:0] exp3_active;
   logic [15:0] length_active;
   logic [15:0] unit_active;
   logic [12:0] gain_delayed;
   logic [12:0] gain_active;
   logic [8:0] dark_active;
   logic [11:0] filler_active;

   wire exp_update = frame_start || !exposure_sync_enable;
   wire lat_comp = analog_gain_setup[GAIN_LAT_COMP_BIT];
   wire [12:0] gain_field = analog_gain_setup[GAIN_SECOND_MSB:0];

   always_ff @(posedge clock) begin
      if (reset) begin
         exp_active <= RST_ZERO;
         exp2_active <= RST_ZERO;
         exp3_active <= RST_ZERO;
         length_active <= RST_ZERO;
         unit_active <= RST_TIME_UNIT_DIVIDER;
      end else if (exp_update) begin
         exp_active <= integration_time;
         exp2_active <= integration_time_second_slope;
         exp3_active <= integration_time_third_slope;
         length_active <= frame_period_length;
         unit_active <= time_unit_divider;
      end
   end

   // gain taken at next frame start
   always_ff @(posedge clock) begin
      if (reset) begin
         gain_delayed <= RST_ANALOG_GAIN_SETUP[12:0];
         gain_active <= RST_ANALOG_GAIN_SETUP[12:0];
         digital_gain_value <= RST_DIGITAL_GAIN_SETUP[DIGITAL_GAIN_MSB:0];
         dark_active <= RST_DARK_ROW_SETUP[8:0];
         filler_active <= RST_FILLER_ROW_COUNT[FILLER_MSB:0];
      end else if (frame_start) begin
         gain_delayed <= gain_field;
         gain_active <= lat_comp ? gain_delayed : gain_field;
         digital_gain_value <= digital_gain_setup[DIGITAL_GAIN_MSB:0];
         dark_active <= dark_row_setup[8:0];
         filler_active <= filler_row_count[FILLER_MSB:0];
      end
   end

   // ------------------------------------------------------------
   // time unit tick generator
   // ------------------------------------------------------------
   logic [15:0] unit_count;

   wire unit_wrap = (unit_count >= unit_active - 16'h0001) || (unit_active == 16'h0000);
   always_ff @(posedge clock) begin
      if (reset || frame_start || unit_wrap) unit_count <= 16'h0000;
      else unit_count <= unit_count + 16'h0001;
   end
   always_ff @(posedge clock) begin
      if (reset) time_unit_tick <= 1'b0;
      else time_unit_tick <= unit_wrap && !frame_start;
   end

   // ------------------------------------------------------------
   // outputs steered by shutter and representation selects
   // ------------------------------------------------------------
   // zero count forced to one
   assign dark_line_count = (dark_active[DARK_COUNT_MSB:0] == 8'h00) ? DARK_COUNT_MIN
                                                                    : dark_active[DARK_COUNT_MSB:0];
   assign blank_first_line = dark_active[BLANK_FIRST_BIT];
   assign filler_line_count = rolling_shutter_enable ? filler_active : 12'h000;
   assign time_unit_length = unit_active;
   assign reset_length = (!rolling_shutter_enable && !period_representation_select) ? length_active : 16'h0000;
   assign frame_length = (!rolling_shutter_enable && period_representation_select) ? length_active : 16'h0000;
   assign exposure_tick = rolling_shutter_enable ? line_tick : time_unit_tick;
   assign integration_time_active = exp_active;
   assign second_slope_integration_time = rolling_shutter_enable ? 16'h0000 : exp2_active;
   assign third_slope_integration_time = rolling_shutter_enable ? 16'h0000 : exp3_active;
   assign analog_gain_first = gain_active[GAIN_FIRST_MSB:0];
   assign analog_gain_second = gain_active[GAIN_SECOND_MSB:GAIN_SECOND_LSB];
endmodule
`default_nettype wire

// [hdl/sfeg_serial_port.sv]
/*
 * sfeg_serial_port: four-wire serial configuration port slave.
 * Assumes: serial clock idles low, at most one eighth of clock; data is
 * taken on its rising edge and driven on its falling edge, MSB first.
 */
`timescale 1ns/1ps
`default_nettype none
module sfeg_serial_port
   import sfeg_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic ser_clock,
   input wire logic ser_select_n,
   input wire logic ser_data_in,
   output logic ser_data_out,
   output logic ser_data_out_oe,
   output logic [8:0] reg_addr,
   output logic reg_write,
   output logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata
);
   // ------------------------------------------------------------
   // pin synchronisers and filtered levels
   // ------------------------------------------------------------
   logic [2:0] sck_sync;
   logic [2:0] sel_sync;
   logic [2:0] din_sync;
   logic sck_level;
   logic sel_level;
   logic [4:0] bit_count;
   logic [15:0] shift_in;
   logic [15:0] shift_out;
   logic read_load;

   // three stages per pin; clock and select levels count once stages two and three agree, data is taken from stage three
   always_ff @(posedge clock) begin
      sck_sync <= {sck_sync[1:0], ser_clock};
      sel_sync <= {sel_sync[1:0], ser_select_n};
      din_sync <= {din_sync[1:0], ser_data_in};
   end

   wire sck_agree = (sck_sync[1] == sck_sync[2]);
   wire sel_agree = (sel_sync[1] == sel_sync[2]);
   wire sck_rise = sck_agree && sck_sync[2] && !sck_level;
   wire sck_fall = sck_agree && !sck_sync[2] && sck_level;
   wire selected = !sel_level;
   wire take_bit = selected && sck_rise;
   wire data_bit = din_sync[2];

   always_ff @(posedge clock) begin
      if (reset) begin
         sck_level <= 1'b0;
         sel_level <= 1'b1;
      end else begin
         if (sck_agree) sck_level <= sck_sync[2];
         if (sel_agree) sel_level <= sel_sync[2];
      end
   end

   // ------------------------------------------------------------
   // frame decode
   // ------------------------------------------------------------
   // shift in address, direction and data
   always_ff @(posedge clock) begin
      if (reset || !selected) begin
         bit_count <= 5'h00;
         shift_in <= 16'h0000;
         reg_addr <= 9'h000;
         reg_write <= 1'b0;
         read_load <= 1'b0;
         reg_wdata <= 16'h0000;
      end else begin
         // at the last bit the direction bit has moved up to the top of the shift register
         reg_write <= take_bit && (bit_count == SER_LAST_BIT) && shift_in[15];
         read_load <= take_bit && (bit_count == SER_RW_BIT) && !data_bit;
         if (take_bit) begin
            shift_in <= {shift_in[14:0], data_bit};
            // count parks one past the last bit so extra bits are ignored
            if (bit_count <= SER_LAST_BIT) bit_count <= bit_count + 5'h01;
            if (bit_count == SER_ADDR_LAST) reg_addr <= {shift_in[7:0], data_bit};
            if (bit_count == SER_LAST_BIT) reg_wdata <= {shift_in[14:0], data_bit};
         end
      end
   end

   // read data: load after the direction bit, shift on falling edges
   always_ff @(posedge clock) begin
      if (reset) begin
         shift_out <= 16'h0000;
      end else if (read_load) begin
         shift_out <= reg_rdata;
      end else if (selected && sck_fall && bit_count > SER_FIRST_DATA) begin
         shift_out <= {shift_out[14:0], 1'b0};
      end
   end

   assign ser_data_out = shift_out[15];
   assign ser_data_out_oe = selected;
endmodule
`default_nettype wire

// [sim/sfeg_regs_assertions.sv]
/* sfeg_regs_assertions: port checks of the frame, exposure and gain slice.
   Assumes: bound to sfeg_regs, one clock, synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module sfeg_regs_assertions (
   input wire logic clock,
   input wire logic reset,
   input wire logic ser_select_n,
   input wire logic ser_data_out_oe,
   input wire logic rolling_shutter_enable,
   input wire logic period_representation_select,
   input wire logic exposure_sync_enable,
   input wire logic frame_start,
   input wire logic line_tick,
   input wire logic [7:0] dark_line_count,
   input wire logic [11:0] filler_line_count,
   input wire logic [15:0] time_unit_length,
   input wire logic time_unit_tick,
   input wire logic [15:0] reset_length,
   input wire logic [15:0] frame_length,
   input wire logic exposure_tick,
   input wire logic [15:0] integration_time_active,
   input wire logic [15:0] second_slope_integration_time,
   input wire logic [15:0] third_slope_integration_time,
   input wire logic [4:0] analog_gain_first,
   input wire logic [7:0] analog_gain_second,
   input wire logic [11:0] digital_gain_value
);
   logic [1:0] fs_q;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // remembers frame starts of the last two cycles
   always_ff @(posedge clock) begin
      fs_q <= reset ? 2'h0 : {fs_q[0], frame_start};
   end
   a_dark_never_zero: assert property (dark_line_count != 8'h00)
      else $error("dark line count is zero");
   a_dark_frame_hold: assert property (fs_q == 2'h0 |-> $stable(dark_line_count))
      else $error("dark line count moved off frame start");
   a_filler_global_zero: assert property (!rolling_shutter_enable |-> filler_line_count == 12'h000)
      else $error("filler lines in global shutter");
   a_frame_len_select: assert property ((rolling_shutter_enable || !period_representation_select)
      |-> frame_length == 16'h0000)
      else $error("frame length shown when not selected");
   a_reset_len_select: assert property ((rolling_shutter_enable || period_representation_select)
      |-> reset_length == 16'h0000)
      else $error("reset length shown when not selected");
   a_slopes_rolling_zero: assert property (rolling_shutter_enable |->
      second_slope_integration_time == 16'h0000 && third_slope_integration_time == 16'h0000)
      else $error("slope exposure used in rolling shutter");
   a_exposure_tick_src: assert property (exposure_tick == (rolling_shutter_enable ? line_tick : time_unit_tick))
      else $error("exposure tick from wrong source");
   a_gain_frame_hold: assert property (fs_q == 2'h0 |-> $stable(analog_gain_first)
      && $stable(analog_gain_second) && $stable(digital_gain_value))
      else $error("gain moved off frame start");
   a_exposure_sync_hold: assert property ($past(exposure_sync_enable) && exposure_sync_enable
      && fs_q == 2'h0 |-> $stable(integration_time_active))
      else $error("exposure moved off frame start");
   // a frame start restarts the divider, so attempts that meet one are dropped
   a_unit_tick_period: assert property (disable iff (reset || frame_start)
      time_unit_tick && time_unit_length == 16'h0003
      && $stable(time_unit_length) |=> !time_unit_tick [*2] ##1 time_unit_tick)
      else $error("time unit tick period wrong");
   a_select_oe_off: assert property (ser_select_n [*5] |-> !ser_data_out_oe)
      else $error("serial output driven while deselected");
   c_frame: cover property (frame_start);
   c_rolling_tick: cover property (exposure_tick && rolling_shutter_enable);
   c_serial_drive: cover property (ser_data_out_oe);
endmodule
bind sfeg_regs sfeg_regs_assertions i_sfeg_regs_assertions (.clock, .reset, .ser_select_n, .ser_data_out_oe,
   .rolling_shutter_enable, .period_representation_select, .exposure_sync_enable, .frame_start, .line_tick,
   .dark_line_count, .filler_line_count, .time_unit_length, .time_unit_tick, .reset_length, .frame_length,
   .exposure_tick, .integration_time_active, .second_slope_integration_time, .third_slope_integration_time,
   .analog_gain_first, .analog_gain_second, .digital_gain_value);
`default_nettype wire

// [sim/test_sensor_frame_exposure_gain_regs.sv]
/* test_sensor_frame_exposure_gain_regs: self-checking bench of sfeg_regs.
   Assumes: checker bound by its own file; stimulus moves at falling edges. */
`timescale 1ns/1ps
`default_nettype none
module test_sensor_frame_exposure_gain_regs;
   import sfeg_pkg::*;
   logic clock, reset, ser_clock, ser_select_n, ser_data_in, ser_data_out, ser_data_out_oe;
   logic rolling, rep_sel, sync_en, frame_start, line_tick, blank, unit_tick, exp_tick;
   logic [7:0] dark, gain2;
   logic [11:0] filler, dgain;
   logic [15:0] unit_len, rst_len, frm_len, integ, slope2, slope3;
   logic [4:0] gain1;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [8:0] addrs [9] = '{ADDR_DARK_ROW_SETUP, ADDR_FILLER_ROW_COUNT, ADDR_TIME_UNIT_DIVIDER,
      ADDR_FRAME_PERIOD_LENGTH, ADDR_INTEGRATION_TIME, ADDR_INTEGRATION_TIME_SECOND_SLOPE,
      ADDR_INTEGRATION_TIME_THIRD_SLOPE, ADDR_ANALOG_GAIN_SETUP, ADDR_DIGITAL_GAIN_SETUP};
   logic [15:0] rsts [9] = '{16'h0102, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h01E2, 16'h0080};
   logic [15:0] masks [9] = '{16'h01FF, 16'h0FFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
      16'h3FFF, 16'h0FFF};

   sfeg_regs i_sfeg_regs (.clock(clock), .reset(reset), .ser_clock(ser_clock), .ser_select_n(ser_select_n),
      .ser_data_in(ser_data_in), .ser_data_out(ser_data_out), .ser_data_out_oe(ser_data_out_oe),
      .rolling_shutter_enable(rolling), .period_representation_select(rep_sel), .exposure_sync_enable(sync_en),
      .frame_start(frame_start), .line_tick(line_tick), .dark_line_count(dark), .blank_first_line(blank),
      .filler_line_count(filler), .time_unit_length(unit_len), .time_unit_tick(unit_tick),
      .reset_length(rst_len), .frame_length(frm_len), .exposure_tick(exp_tick),
      .integration_time_active(integ), .second_slope_integration_time(slope2),
      .third_slope_integration_time(slope3), .analog_gain_first(gain1), .analog_gain_second(gain2),
      .digital_gain_value(dgain));

   // ----------------------------------------
   // clock and hang guard
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         test_done();
      end
   end

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic test_done();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clock);
   endtask
   // one serial frame, bits change while the serial clock is low
   task automatic ser_frame(input logic [8:0] a, input logic wr, input logic [15:0] d, output logic [15:0] q);
      logic [25:0] bits;
      bits = {a, wr, d};
      q = 16'h0000;
      ser_select_n = 1'b0;
      wait_clk(8);
      for (int i = 25; i >= 0; i--) begin
         ser_data_in = bits[i];
         wait_clk(8);
         if (i < 16) q = {q[14:0], ser_data_out};
         ser_clock = 1'b1;
         wait_clk(8);
         ser_clock = 1'b0;
      end
      wait_clk(8);
      ser_select_n = 1'b1;
      ser_data_in = ~ser_data_in;
      wait_clk(8);
   endtask
   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      logic [15:0] q;
      ser_frame(a, 1'b1, d, q);
   endtask
   task automatic rd(input logic [8:0] a, input logic [15:0] exp);
      logic [15:0] q;
      ser_frame(a, 1'b0, 16'h0000, q);
      check($sformatf("register %h", a), q, exp);
   endtask
   task automatic pulse_frame();
      frame_start = 1'b1;
      wait_clk(1);
      frame_start = 1'b0;
      wait_clk(2);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      for (int i = 0; i < 9; i++) rd(addrs[i], rsts[i]);
      check("dark", dark, 16'h0002);
      check("blank", blank, 16'h0001);
      check("unit", unit_len, 16'h0001);
      check("gain1", gain1, 16'h0002);
      check("gain2", gain2, 16'h000F);
      check("dgain", dgain, 16'h0080);
      $display("test reset done");
   endtask
   task automatic t_access();
      for (int i = 0; i < 9; i++) begin
         wr(addrs[i], 16'hFFFF);
         rd(addrs[i], masks[i]);
      end
      wr(9'h0C4, 16'hFFFF);
      rd(9'h0C4, 16'h0000);
      $display("test access done");
   endtask
   task automatic t_lines();
      wr(ADDR_DARK_ROW_SETUP, 16'h0000);
      wr(ADDR_FILLER_ROW_COUNT, 16'h07FF);
      check("dark held", dark, 16'h0002);
      rolling = 1'b1;
      pulse_frame();
      check("dark zero", dark, 16'h0001);
      check("blank off", blank, 16'h0000);
      check("filler", filler, 16'h07FF);
      rolling = 1'b0;
      wait_clk(1);
      check("filler global", filler, 16'h0000);
      wr(ADDR_DARK_ROW_SETUP, 16'h01FF);
      pulse_frame();
      check("dark max", dark, 16'h00FF);
      check("blank on", blank, 16'h0001);
      $display("test lines done");
   endtask
   task automatic t_gain();
      wr(ADDR_ANALOG_GAIN_SETUP, 16'h0243);
      wr(ADDR_DIGITAL_GAIN_SETUP, 16'h0ABC);
      pulse_frame();
      check("gain1 now", gain1, 16'h0003);
      check("gain2 now", gain2, 16'h0012);
      check("dgain now", dgain, 16'h0ABC);
      wr(ADDR_ANALOG_GAIN_SETUP, 16'h2405);
      pulse_frame();
      check("gain1 late", gain1, 16'h0003);
      pulse_frame();
      check("gain1 next", gain1, 16'h0005);
      check("gain2 next", gain2, 16'h0020);
      $display("test gain done");
   endtask
   task automatic t_expo();
      int n;
      n = 0;
      wr(ADDR_TIME_UNIT_DIVIDER, 16'h0003);
      wr(ADDR_FRAME_PERIOD_LENGTH, 16'h1234);
      wr(ADDR_INTEGRATION_TIME, 16'h0100);
      wr(ADDR_INTEGRATION_TIME_SECOND_SLOPE, 16'h0200);
      wr(ADDR_INTEGRATION_TIME_THIRD_SLOPE, 16'h0300);
      check("exp held", integ, 16'hFFFF);
      pulse_frame();
      check("exp", integ, 16'h0100);
      check("slope2", slope2, 16'h0200);
      check("slope3", slope3, 16'h0300);
      check("frame len", frm_len, 16'h1234);
      check("reset len off", rst_len, 16'h0000);
      rep_sel = 1'b0;
      wait_clk(1);
      check("reset len", rst_len, 16'h1234);
      repeat (30) begin
         wait_clk(1);
         n += exp_tick;
      end
      check("unit ticks", n[15:0], 16'h000A);
      rolling = 1'b1;
      wait_clk(1);
      check("slope2 rolling", slope2, 16'h0000);
      check("slope3 rolling", slope3, 16'h0000);
      line_tick = 1'b1;
      #1 check("line tick", exp_tick, 16'h0001);
      wait_clk(1);
      line_tick = 1'b0;
      sync_en = 1'b0;
      wr(ADDR_INTEGRATION_TIME, 16'h0055);
      check("exp free", integ, 16'h0055);
      sync_en = 1'b1;
      rolling = 1'b0;
      $display("test exposure done");
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {ser_clock, ser_data_in, rolling, frame_start, line_tick} = 5'h00;
      {reset, ser_select_n, rep_sel, sync_en} = 4'hF;
      wait_clk(4);
      reset = 1'b0;
      wait_clk(4);
      t_reset();
      t_access();
      t_lines();
      t_gain();
      t_expo();
      test_done();
   end
endmodule
`default_nettype wire
